// [hw/itmr_pkg.sv]
package itmr_pkg;
    // Bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [7:0] OFF_COUNT_VALUE  = 8'h02;
    localparam logic [7:0] OFF_MODULO_VALUE = 8'h03;
    localparam logic [7:0] OFF_XFER_BUF     = 8'h04;
    localparam logic [7:0] OFF_TIMER_MODE   = 8'h11;
    localparam logic [7:0] OFF_OUT_ROUTING  = 8'h12;
    localparam logic [7:0] OFF_IRQ_STATUS   = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK     = 8'h21;

    // Timer mode fields
    localparam int MODE_SEL_LO_BIT = 0;
    localparam int MODE_SEL_HI_BIT = 1;
    localparam int MODE_CLEAR_BIT  = 2;
    localparam int MODE_RUN_BIT    = 3;

    // Output routing and status fields
    localparam int ROUTE_SEL_BIT   = 0;
    localparam int STAT_MATCH_BIT  = 0;
    localparam int STAT_WAIT_BIT   = 1;
    localparam int STAT_W          = 2;

    // Reset values
    localparam logic [7:0] MODULO_RST  = 8'hFF;
    localparam logic [1:0] PSEL_RST    = 2'h0;
    localparam logic       RUN_RST     = 1'b1;
    localparam logic [3:0] ROUTE_RST   = 4'h0;
    localparam logic       MATCH_FF_RST = 1'b0;

    // Prescaler taps: divide by 2*2^tap gives fx/32, fx/256, fx/2048
    localparam int PRESC_W   = 11;
    localparam int TAP_DIV32   = 4;
    localparam int TAP_DIV256  = 7;
    localparam int TAP_DIV2048 = 10;

    // Clock
    localparam int CLK_PERIOD_NS = 50;

    typedef enum logic [1:0] {
        PSEL_DIV256,
        PSEL_DIV32,
        PSEL_DIV2048,
        PSEL_EXT_PIN
    } pulse_sel_t;
endpackage

// [hw/interval_timer_read_and_output.sv]
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module interval_timer_read_and_output (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    // Register port
    input  wire logic [itmr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [itmr_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [itmr_pkg::DATA_W-1:0] reg_rdata,
    // External count source
    input  wire logic                        ext_int_pin,
    // Port logic beside the shared pin
    input  wire logic                        shared_pin_direction_bit,
    input  wire logic                        port_out_data,
    // Shared open-drain pin
    input  wire logic                        shared_port_pin_i,
    output logic                             shared_port_pin_o,
    output logic                             shared_port_pin_oe,
    output logic                             port_in_data,
    // Status
    output logic                             osc_wait_busy,
    output logic                             irq
);
    import itmr_pkg::*;

    logic [PRESC_W-1:0] presc_ff;
    logic [7:0]         count_ff;
    logic [7:0]         modulo_ff;
    logic [DATA_W-1:0]  xfer_buf_ff;
    logic [1:0]         psel_ff;
    logic               run_ff;
    logic               run_prev_ff;
    logic               match_out_select_ff;
    logic               lvl_prev_ff;
    logic               pend_ff;
    logic               match_ff;
    logic               wait_ff;
    logic [STAT_W-1:0]  status_ff;
    logic [STAT_W-1:0]  mask_ff;
    logic [DATA_W-1:0]  rdata_ff;

    // Address decode
    wire wr_mode   = reg_wr && (reg_addr == OFF_TIMER_MODE);
    wire wr_route  = reg_wr && (reg_addr == OFF_OUT_ROUTING);
    wire wr_buf    = reg_wr && (reg_addr == OFF_XFER_BUF);
    wire wr_modulo = reg_wr && (reg_addr == OFF_MODULO_VALUE);
    wire wr_stat   = reg_wr && (reg_addr == OFF_IRQ_STATUS);
    wire wr_mask   = reg_wr && (reg_addr == OFF_IRQ_MASK);
    wire get_now   = reg_rd && (reg_addr == OFF_COUNT_VALUE);
    wire clr_req   = wr_mode && reg_wdata[MODE_CLEAR_BIT];

    // Count pulse selection
    wire pulse_sel_t psel = pulse_sel_t'(psel_ff);
    wire pulse_lvl =
        (psel == PSEL_DIV32)   ? presc_ff[TAP_DIV32]   :
        (psel == PSEL_DIV2048) ? presc_ff[TAP_DIV2048] :
        (psel == PSEL_EXT_PIN) ? ext_int_pin           :
                                 presc_ff[TAP_DIV256];
    wire pulse_rise = pulse_lvl && !lvl_prev_ff;
    wire run_start  = run_ff && !run_prev_ff;
    // Low level at start counts the starting instant
    wire start_cnt  = run_start && !pulse_lvl;
    wire cnt_evt    = run_ff && (pulse_rise || start_cnt);
    // Counter frozen in a read cycle, pending pulse applied later
    wire eff_cnt    = run_ff && !get_now && (cnt_evt || pend_ff);
    wire match      = eff_cnt && (count_ff == modulo_ff);
    wire [7:0] count_inc = count_ff + 8'h01;

    wire [STAT_W-1:0] stat_set = {match && wait_ff, match};
    wire [STAT_W-1:0] stat_clr = wr_stat ? reg_wdata[STAT_W-1:0] : '0;

    // Read data mux
    wire [DATA_W-1:0] get_val = {xfer_buf_ff[DATA_W-1:8], count_ff};
    wire [DATA_W-1:0] rd_mux =
        (reg_addr == OFF_COUNT_VALUE) ? get_val :
        (reg_addr == OFF_XFER_BUF)    ? xfer_buf_ff :
        (reg_addr == OFF_TIMER_MODE)  ? DATA_W'({run_ff, 1'b0, psel_ff}) :
        (reg_addr == OFF_OUT_ROUTING) ? DATA_W'(match_out_select_ff) :
        (reg_addr == OFF_IRQ_STATUS)  ? DATA_W'(status_ff) :
        (reg_addr == OFF_IRQ_MASK)    ? DATA_W'(mask_ff) :
                                        '0;

    // Free running prescaler, never cleared by software
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            presc_ff    <= '0;
            lvl_prev_ff <= 1'b0;
        end else begin
            presc_ff    <= presc_ff + PRESC_W'(1);
            lvl_prev_ff <= pulse_lvl;
        end
    end

    // Mode, routing and modulo registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            psel_ff             <= PSEL_RST;
            run_ff              <= RUN_RST;
            run_prev_ff         <= 1'b0;
            match_out_select_ff <= ROUTE_RST[ROUTE_SEL_BIT];
            modulo_ff           <= MODULO_RST;
        end else begin
            run_prev_ff <= run_ff;
            if (wr_mode) begin
                psel_ff <= {reg_wdata[MODE_SEL_HI_BIT], reg_wdata[MODE_SEL_LO_BIT]};
                run_ff  <= reg_wdata[MODE_RUN_BIT];
            end
            if (wr_route) begin
                match_out_select_ff <= reg_wdata[ROUTE_SEL_BIT];
            end
            if (wr_modulo) begin
                modulo_ff <= xfer_buf_ff[7:0];
            end
        end
    end

    // Count register, pending pulse and match flip-flop
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_ff <= '0;
            pend_ff  <= 1'b0;
            match_ff <= MATCH_FF_RST;
        end else if (clr_req) begin
            count_ff <= '0;
            pend_ff  <= 1'b0;
            match_ff <= MATCH_FF_RST;
        end else begin
            pend_ff <= get_now && (cnt_evt || pend_ff);
            if (match) begin
                count_ff <= '0;
                match_ff <= !match_ff;
            end else if (eff_cnt) begin
                count_ff <= count_inc;
            end
        end
    end

    // Transfer buffer, oscillation wait, interrupt status and mask
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            xfer_buf_ff <= '0;
            wait_ff     <= 1'b1;
            status_ff   <= '0;
            mask_ff     <= '0;
        end else begin
            if (get_now) begin
                xfer_buf_ff <= get_val;
            end else if (wr_buf) begin
                xfer_buf_ff <= reg_wdata;
            end
            if (match) begin
                wait_ff <= 1'b0;
            end
            status_ff <= (status_ff & ~stat_clr) | stat_set;
            if (wr_mask) begin
                mask_ff <= reg_wdata[STAT_W-1:0];
            end
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : '0;
        end
    end

    // N-ch open drain: only pulls low
    wire pin_pull = match_out_select_ff ? match_ff :
                    (shared_pin_direction_bit && !port_out_data);

    assign reg_rdata          = rdata_ff;
    assign shared_port_pin_o  = 1'b0;
    assign shared_port_pin_oe = pin_pull;
    assign port_in_data       = shared_port_pin_i;
    assign osc_wait_busy      = wait_ff;
    assign irq                = |(status_ff & mask_ff);

    // Checks
    clear_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clr_req |=> (count_ff == 8'h00) && (match_ff == MATCH_FF_RST))
        else $error("clear did not zero count and match ff");
    presc_free_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clr_req |=> presc_ff == $past(presc_ff) + PRESC_W'(1))
        else $error("prescaler disturbed by clear");
    match_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        match && !clr_req |=> count_ff == 8'h00 && status_ff[STAT_MATCH_BIT])
        else $error("match did not wrap count or set flag");
    toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        match && !clr_req |=> match_ff != $past(match_ff))
        else $error("match ff did not toggle");
    run_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !run_ff && !clr_req |=> count_ff == $past(count_ff))
        else $error("count moved while halted");
    get_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        get_now && !clr_req |=> count_ff == $past(count_ff))
        else $error("count moved during read");
    get_copy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        get_now && !clr_req |=> xfer_buf_ff == {$past(xfer_buf_ff[DATA_W-1:8]),
                                                $past(count_ff)})
        else $error("read did not copy count into buffer");
    pend_apply_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        get_now && cnt_evt && !clr_req ##1 run_ff && !get_now && !clr_req
        && count_ff != modulo_ff |=> count_ff == $past(count_inc))
        else $error("pending pulse lost after read");
    pin_route_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        match_out_select_ff |-> shared_port_pin_oe == match_ff)
        else $error("pin does not follow match ff");
    modulo_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_modulo |=> modulo_ff == $past(xfer_buf_ff[7:0]))
        else $error("modulo not loaded from buffer");
    start_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run_start && !pulse_lvl && !get_now |-> eff_cnt)
        else $error("start at low level did not count");

    // Wait, status and interrupt
    wait_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        match |=> !wait_ff)
        else $error("wait flag not cleared by match");
    wait_stay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wait_ff |=> !wait_ff)
        else $error("wait flag rose again");
    stat_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        match && wait_ff |=> status_ff[STAT_WAIT_BIT])
        else $error("wait done status not set");
    stat_w1c_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_stat && reg_wdata[STAT_MATCH_BIT] && !match |=> !status_ff[STAT_MATCH_BIT])
        else $error("status bit not cleared by write one");
    stat_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        status_ff[STAT_MATCH_BIT] && !(wr_stat && reg_wdata[STAT_MATCH_BIT])
        |=> status_ff[STAT_MATCH_BIT])
        else $error("status bit dropped without clear");
    stat_set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        match && wr_stat |=> status_ff[STAT_MATCH_BIT])
        else $error("clear beat a new match");
    mask_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_mask |=> mask_ff == $past(reg_wdata[STAT_W-1:0]))
        else $error("mask not loaded");
    irq_source_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        irq |-> status_ff != '0)
        else $error("interrupt without status");

    // Shared pin
    pin_port_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !match_out_select_ff |->
        shared_port_pin_oe == (shared_pin_direction_bit && !port_out_data))
        else $error("pin does not follow port latch");
    oe_dir_ign_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        match_out_select_ff && shared_pin_direction_bit |-> shared_port_pin_oe == match_ff)
        else $error("direction bit leaked into match output");
    route_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_route |=> match_out_select_ff == $past(reg_wdata[ROUTE_SEL_BIT]))
        else $error("output select not loaded");

    // Counter core
    presc_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> presc_ff == $past(presc_ff) + PRESC_W'(1))
        else $error("prescaler skipped a step");
    clear_pend_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clr_req |=> !pend_ff)
        else $error("pending pulse survived clear");
    count_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        eff_cnt && !match && !clr_req |=> count_ff == $past(count_inc))
        else $error("count did not advance by one");
    idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !eff_cnt && !clr_req |=> count_ff == $past(count_ff))
        else $error("count moved without a pulse");
    start_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run_start && lvl_prev_ff && pulse_lvl && !pend_ff |-> !eff_cnt)
        else $error("start at high level counted at once");
    get_no_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        get_now |-> !match)
        else $error("match during count read");
    halt_no_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !run_ff |-> !match)
        else $error("match while halted");
    match_ff_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !match && !clr_req |=> match_ff == $past(match_ff))
        else $error("match ff moved without match");
    pend_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        get_now && (cnt_evt || pend_ff) && !clr_req |=> pend_ff)
        else $error("pulse in read cycle not remembered");
    modulo_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wr_modulo |=> modulo_ff == $past(modulo_ff))
        else $error("modulo changed without write");

    // Register port
    mode_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_mode |=> psel_ff == $past({reg_wdata[MODE_SEL_HI_BIT], reg_wdata[MODE_SEL_LO_BIT]}))
        else $error("pulse select not loaded");
    run_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_mode |=> run_ff == $past(reg_wdata[MODE_RUN_BIT]))
        else $error("run flag not loaded");
    buf_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_buf && !get_now |=> xfer_buf_ff == $past(reg_wdata))
        else $error("transfer buffer not written");
    buf_upper_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        get_now |=> xfer_buf_ff[DATA_W-1:8] == $past(xfer_buf_ff[DATA_W-1:8]))
        else $error("count read changed buffer upper byte");
    rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside read");
    rdata_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        get_now |=> reg_rdata == xfer_buf_ff)
        else $error("count read data differs from buffer");

    // Covers
    match_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n) match);
    get_pend_c:   cover property (@(posedge ref_clk) disable iff (!rst_n)
        get_now && cnt_evt);
    clear_run_c:  cover property (@(posedge ref_clk) disable iff (!rst_n)
        clr_req && run_ff);
    pin_drive_c:  cover property (@(posedge ref_clk) disable iff (!rst_n)
        match_out_select_ff && shared_port_pin_oe);
    start_high_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        run_start && pulse_lvl);
endmodule

// [verification/core_model.sv]
`timescale 1ns/1ps
module core_model (
    // Clock
    input  wire logic                        ref_clk,
    // Register port
    output logic      [itmr_pkg::ADDR_W-1:0] reg_addr,
    output logic      [itmr_pkg::DATA_W-1:0] reg_wdata,
    output logic                             reg_wr,
    output logic                             reg_rd,
    input  wire logic [itmr_pkg::DATA_W-1:0] reg_rdata
);
    import itmr_pkg::*;

    initial begin
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write, data inverted once released
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // One-cycle read, answer taken in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
endmodule

// [verification/interval_timer_read_and_output_tb_top.sv]
`timescale 1ns/1ps
module interval_timer_read_and_output_tb_top;
    import itmr_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rdv;
    logic              reg_wr;
    logic              reg_rd;
    logic              ext_int_pin = 1'b0;
    logic              dir_bit = 1'b0;
    logic              port_out_data = 1'b0;
    logic              pin_o;
    logic              pin_oe;
    logic              port_in_data;
    logic              osc_wait_busy;
    logic              irq;
    wire               pin_level;
    int                num_errors = 0;
    int                check_count = 0;
    int                cycles = 0;

    // Open drain with pull-up
    assign pin_level = pin_oe ? pin_o : 1'b1;

    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    core_model i_core_model (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    interval_timer_read_and_output i_interval_timer_read_and_output (.ref_clk(ref_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_int_pin(ext_int_pin),
        .shared_pin_direction_bit(dir_bit), .port_out_data(port_out_data),
        .shared_port_pin_i(pin_level), .shared_port_pin_o(pin_o),
        .shared_port_pin_oe(pin_oe), .port_in_data(port_in_data),
        .osc_wait_busy(osc_wait_busy), .irq(irq));

    task automatic results();
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Edges spaced well apart, one per several cycles
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            ext_int_pin <= 1'b1;
            repeat (2) @(posedge ref_clk);
            ext_int_pin <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk("busy_rst", osc_wait_busy, 1'b1);
        i_core_model.rd(OFF_OUT_ROUTING, rdv);
        chk("routing_rst", rdv, 16'h0000);
        i_core_model.rd(OFF_TIMER_MODE, rdv);
        chk("mode_rst", rdv, 16'h0008);
        i_core_model.rd(8'h7F, rdv);
        chk("unmapped", rdv, 16'h0000);
        // Fast source shortens the start-up wait
        i_core_model.wr(OFF_TIMER_MODE, 16'h0009);
        for (int i = 0; i < 9000 && osc_wait_busy; i++) @(posedge ref_clk);
        chk("busy_done", osc_wait_busy, 1'b0);
        i_core_model.rd(OFF_IRQ_STATUS, rdv);
        chk("status_wait", rdv, 16'h0003);
        chk("irq_masked", irq, 1'b0);
        i_core_model.wr(OFF_IRQ_STATUS, 16'h0003);
        i_core_model.rd(OFF_IRQ_STATUS, rdv);
        chk("status_w1c", rdv, 16'h0000);
        // External edges, modulo 2, clear
        i_core_model.wr(OFF_XFER_BUF, 16'hAB02);
        i_core_model.wr(OFF_MODULO_VALUE, 16'h0000);
        i_core_model.wr(OFF_TIMER_MODE, 16'h000F);
        i_core_model.wr(OFF_IRQ_MASK, 16'h0001);
        i_core_model.wr(OFF_OUT_ROUTING, 16'h0001);
        chk("oe_cleared", pin_oe, 1'b0);
        pulse(2);
        i_core_model.rd(OFF_COUNT_VALUE, rdv);
        chk("count_two", rdv, 16'hAB02);
        chk("irq_none", irq, 1'b0);
        pulse(1);
        chk("irq_match", irq, 1'b1);
        chk("pin_match", pin_level, 1'b0);
        i_core_model.rd(OFF_COUNT_VALUE, rdv);
        chk("count_zero", rdv, 16'hAB00);
        dir_bit       <= 1'b1;
        port_out_data <= 1'b1;
        pulse(2);
        chk("oe_dir_ign", pin_oe, 1'b1);
        pulse(1);
        chk("oe_second", pin_oe, 1'b0);
        i_core_model.wr(OFF_OUT_ROUTING, 16'h0000);
        port_out_data <= 1'b0;
        @(negedge ref_clk);
        chk("oe_port_low", pin_oe, 1'b1);
        chk("port_in", port_in_data, 1'b0);
        port_out_data <= 1'b1;
        @(negedge ref_clk);
        chk("oe_port_hi", pin_oe, 1'b0);
        i_core_model.wr(OFF_IRQ_STATUS, 16'h0001);
        @(negedge ref_clk);
        chk("irq_clear", irq, 1'b0);
        // Edge while reads keep freezing the count
        fork
            pulse(1);
            repeat (8) i_core_model.rd(OFF_COUNT_VALUE, rdv);
        join
        i_core_model.rd(OFF_COUNT_VALUE, rdv);
        chk("count_frz", rdv, 16'hAB01);
        i_core_model.wr(OFF_TIMER_MODE, 16'h0003);
        pulse(2);
        i_core_model.rd(OFF_COUNT_VALUE, rdv);
        chk("count_held", rdv, 16'hAB01);
        // Start with the source low counts at once
        i_core_model.wr(OFF_TIMER_MODE, 16'h000B);
        repeat (4) @(posedge ref_clk);
        i_core_model.rd(OFF_COUNT_VALUE, rdv);
        chk("count_start", rdv, 16'hAB02);
        results();
    end
endmodule
